// >>> include/mtc_pkg.sv
// Shared constants, register map and state layout of the modulo timer core.
`default_nettype none
package mtc_pkg;
    // Byte offsets of the registers on the bus.
    localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFF_COUNT_HIGH  = 8'h04;
    localparam logic [7:0] OFF_COUNT_LOW   = 8'h08;
    localparam logic [7:0] OFF_LIMIT_HIGH  = 8'h0C;
    localparam logic [7:0] OFF_LIMIT_LOW   = 8'h10;
    localparam logic [7:0] OFF_CHANNEL     = 8'h14;
    // Field positions in timer_control_status.
    localparam int BIT_OVF_FLAG  = 7;
    localparam int BIT_OVF_IE    = 6;
    localparam int BIT_HALT      = 5;
    localparam int BIT_CLEAR     = 4;
    localparam int DIV_LSB       = 0;
    localparam int DIV_W         = 3;
    // Field positions in the channel register.
    localparam int CH_FLAG_LSB   = 0;
    localparam int CH_IE_LSB     = 4;
    localparam int CH_MODE_LSB   = 8;
    localparam int CH0_BUF_BIT   = 12;
    localparam int NUM_CH        = 2;
    // Divider code that selects no clock source.
    localparam logic [2:0] DIV_NONE = 3'h7;
    localparam int PRESC_W = 6;
    localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO  = 16'h0000;

    typedef struct packed {
        logic              ovf_flag;
        logic              ovf_ie;
        logic              halt;
        logic [2:0]        div_sel;
        logic              ovf_armed;
        logic [15:0]       count;
        logic [15:0]       limit;
        logic [5:0]        presc;
        logic [7:0]        low_latch;
        logic              latch_held;
        logic              limit_pend;
        logic [1:0]        ch_flag;
        logic [1:0]        ch_armed;
        logic [1:0]        ch_ie;
        logic [1:0]        ch_mode;
        logic              ch0_buf;
        logic [1:0]        cap_s1;
        logic [1:0]        cap_s2;
        logic [1:0]        cap_prev;
        logic              dp_wr;
        logic [7:0]        dp_addr;
        logic [31:0]       rdata;
        logic              rdy;
        logic              irq_ovf;
        logic [1:0]        irq_ch;
        logic              wake;
    } mtc_state_t;

    localparam mtc_state_t STATE_RESET = '{halt: 1'b1, limit: LIMIT_RESET, rdy: 1'b1,
                                           default: '0};
endpackage
`default_nettype wire

// >>> src/mtc_core.sv
// Modulo timer core with AHB-Lite register slave, overflow flag and channel flags.
`default_nettype none
module mtc_core (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // System state
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    input  wire logic        break_active,
    input  wire logic        break_clear_enable,
    // Channels
    input  wire logic [1:0]  capture_pin,
    input  wire logic [1:0]  compare_hit,
    // Requests
    output logic             overflow_irq,
    output logic [1:0]       channel_irq,
    output logic             wake_request
);
    mtc_pkg::mtc_state_t st_reg;
    mtc_pkg::mtc_state_t st_next;

    logic        acc_ok;
    logic        brk_lock;
    logic        addr_take;
    logic        rd;
    logic        wr_ctrl;
    logic        clr_wr;
    logic        run;
    logic        tick;
    logic        ovf_ev;
    logic        ovf_set;
    logic [1:0]  ch_ev;
    logic [7:0]  rd_addr;

    // A divider code selects a power-of-two mask over the prescaler, which advances only while the timer runs.
    function automatic logic div_tick(input logic [2:0] sel, input logic [5:0] presc);
        logic [6:0] m;
        m = (7'h01 << sel) - 7'h01;
        div_tick = (sel != mtc_pkg::DIV_NONE) && ((presc & m[5:0]) == m[5:0]);
    endfunction

    always_comb begin
        st_next   = st_reg;
        rd_addr   = haddr[7:0];
        acc_ok    = !wait_mode;
        brk_lock  = break_active && !break_clear_enable;
        // Only whole words are moved, so the transfer size is not decoded.
        addr_take = hsel && htrans[1] && hready && acc_ok && (haddr[31:8] == 24'h000000);
        rd        = addr_take && !hwrite;
        st_next.dp_wr   = addr_take && hwrite;
        st_next.dp_addr = rd_addr;
        wr_ctrl   = st_reg.dp_wr && (st_reg.dp_addr == mtc_pkg::OFF_CTRL_STATUS);
        // clear bit is a write strobe only
        clr_wr    = wr_ctrl && hwdata[mtc_pkg::BIT_CLEAR];

        // halt holds count; stop and break freeze it too
        run    = !st_reg.halt && !stop_mode && !break_active;
        tick   = run && div_tick(st_reg.div_sel, st_reg.presc);
        ovf_ev = tick && (st_reg.count == st_reg.limit);
        // no overflow flag while the limit is half written
        ovf_set = ovf_ev && !st_reg.limit_pend;
        if (run) begin
            st_next.presc = st_reg.presc + 6'h01;
        end
        if (tick) begin
            st_next.count = ovf_ev ? mtc_pkg::COUNT_ZERO : st_reg.count + 16'h0001;
        end
        // clear wins over counting; counter zeroed
        if (clr_wr) begin
            st_next.count = mtc_pkg::COUNT_ZERO;
            st_next.presc = '0;
        end

        // Control and status register.
        if (rd && (rd_addr == mtc_pkg::OFF_CTRL_STATUS) && st_reg.ovf_flag && !brk_lock) begin
            st_next.ovf_armed = 1'b1;
        end
        if (wr_ctrl) begin
            st_next.ovf_ie  = hwdata[mtc_pkg::BIT_OVF_IE];
            st_next.halt    = hwdata[mtc_pkg::BIT_HALT];
            st_next.div_sel = hwdata[mtc_pkg::DIV_LSB +: mtc_pkg::DIV_W];
            // clear by write 0 after armed read; allowed unless locked
            if (!hwdata[mtc_pkg::BIT_OVF_FLAG] && st_reg.ovf_armed && !brk_lock) begin
                st_next.ovf_flag  = 1'b0;
                st_next.ovf_armed = 1'b0;
            end
        end
        if (ovf_set) begin
            st_next.ovf_flag  = 1'b1;
            st_next.ovf_armed = 1'b0;
        end

        if (rd && (rd_addr == mtc_pkg::OFF_COUNT_HIGH) && !st_reg.latch_held) begin
            st_next.low_latch  = st_reg.count[7:0];
            st_next.latch_held = 1'b1;
        end
        if (rd && (rd_addr == mtc_pkg::OFF_COUNT_LOW)) begin
            st_next.latch_held = 1'b0;
        end

        // high byte write arms suppression, low byte write releases it
        if (st_reg.dp_wr && (st_reg.dp_addr == mtc_pkg::OFF_LIMIT_HIGH)) begin
            st_next.limit[15:8] = hwdata[7:0];
            st_next.limit_pend  = 1'b1;
        end
        if (st_reg.dp_wr && (st_reg.dp_addr == mtc_pkg::OFF_LIMIT_LOW)) begin
            st_next.limit[7:0] = hwdata[7:0];
            st_next.limit_pend = 1'b0;
        end

        // Capture pins pass two flip-flops before edge detection.
        st_next.cap_s1   = capture_pin;
        st_next.cap_s2   = st_reg.cap_s1;
        st_next.cap_prev = st_reg.cap_s2;
        // A pin edge seen while captures are suppressed is lost, not deferred.
        for (int i = 0; i < mtc_pkg::NUM_CH; i++) begin
            // channel event; captures suppressed while halted or in break
            ch_ev[i] = st_reg.ch_mode[i] ? compare_hit[i]
                     : (st_reg.cap_s2[i] && !st_reg.cap_prev[i] && !st_reg.halt && !break_active);
        end
        if (rd && (rd_addr == mtc_pkg::OFF_CHANNEL) && !brk_lock) begin
            st_next.ch_armed = st_reg.ch_armed | st_reg.ch_flag;
        end
        if (st_reg.dp_wr && (st_reg.dp_addr == mtc_pkg::OFF_CHANNEL)) begin
            st_next.ch_ie   = hwdata[mtc_pkg::CH_IE_LSB +: mtc_pkg::NUM_CH];
            // each channel picks its own function; the channel 0 buffer bit is only stored and read back
            st_next.ch_mode = hwdata[mtc_pkg::CH_MODE_LSB +: mtc_pkg::NUM_CH];
            st_next.ch0_buf = hwdata[mtc_pkg::CH0_BUF_BIT];
            if (!brk_lock) begin
                // channel flags use the same two-step clear
                st_next.ch_flag  = st_reg.ch_flag
                                 & ~(st_reg.ch_armed & ~hwdata[mtc_pkg::CH_FLAG_LSB +: 2]);
                st_next.ch_armed = st_reg.ch_armed & hwdata[mtc_pkg::CH_FLAG_LSB +: 2];
            end
        end
        st_next.ch_flag  = st_next.ch_flag | ch_ev;
        st_next.ch_armed = st_next.ch_armed & ~ch_ev;

        // Read data is driven in the data phase that follows the address phase.
        st_next.rdata = 32'h00000000;
        if (rd) begin
            case (rd_addr)
                mtc_pkg::OFF_CTRL_STATUS: begin
                    st_next.rdata[mtc_pkg::BIT_OVF_FLAG] = st_reg.ovf_flag;
                    st_next.rdata[mtc_pkg::BIT_OVF_IE]   = st_reg.ovf_ie;
                    st_next.rdata[mtc_pkg::BIT_HALT]     = st_reg.halt;
                    st_next.rdata[mtc_pkg::DIV_LSB +: mtc_pkg::DIV_W] = st_reg.div_sel;
                end
                mtc_pkg::OFF_COUNT_HIGH: begin
                    st_next.rdata[7:0] = st_reg.count[15:8];
                end
                mtc_pkg::OFF_COUNT_LOW: begin
                    st_next.rdata[7:0] = st_reg.latch_held ? st_reg.low_latch
                                                           : st_reg.count[7:0];
                end
                mtc_pkg::OFF_LIMIT_HIGH: begin
                    st_next.rdata[7:0] = st_reg.limit[15:8];
                end
                mtc_pkg::OFF_LIMIT_LOW: begin
                    st_next.rdata[7:0] = st_reg.limit[7:0];
                end
                mtc_pkg::OFF_CHANNEL: begin
                    st_next.rdata[mtc_pkg::CH_FLAG_LSB +: 2] = st_reg.ch_flag;
                    st_next.rdata[mtc_pkg::CH_IE_LSB +: 2]   = st_reg.ch_ie;
                    st_next.rdata[mtc_pkg::CH_MODE_LSB +: 2] = st_reg.ch_mode;
                    st_next.rdata[mtc_pkg::CH0_BUF_BIT]      = st_reg.ch0_buf;
                end
                default: begin
                    st_next.rdata = 32'h00000000;
                end
            endcase
        end

        // overflow request; channel requests; any request wakes
        st_next.irq_ovf = st_next.ovf_flag && st_next.ovf_ie;
        st_next.irq_ch  = st_next.ch_flag & st_next.ch_ie;
        st_next.wake    = st_next.irq_ovf || (|st_next.irq_ch);
        // No wait states: every register answers in its own data phase.
        st_next.rdy     = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= mtc_pkg::STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout    = st_reg.rdy;
    assign hrdata       = st_reg.rdata;
    assign hresp        = 1'b0;
    assign overflow_irq = st_reg.irq_ovf;
    assign channel_irq  = st_reg.irq_ch;
    assign wake_request = st_reg.wake;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_wrap_tick;
        tick && (st_reg.count == st_reg.limit) && !clr_wr;
    endsequence

    sequence s_no_capture;
        (st_reg.ch_flag & ~$past(st_reg.ch_flag) & ~$past(st_reg.ch_mode)) == 2'b00;
    endsequence

    property p_tof_set;
        s_wrap_tick and (!st_reg.limit_pend) |=> st_reg.ovf_flag;
    endproperty
    a_tof_set: assert property (p_tof_set) else $error("overflow flag missed");

    property p_wrap;
        s_wrap_tick |=> (st_reg.count == 16'h0000) ##1 (st_reg.count <= 16'h0001);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_irq;
        overflow_irq == (st_reg.ovf_flag && st_reg.ovf_ie);
    endproperty
    a_irq: assert property (p_irq) else $error("overflow request wrong");

    property p_tof_cause;
        $rose(st_reg.ovf_flag) |-> $past(ovf_set);
    endproperty
    a_tof_cause: assert property (p_tof_cause) else $error("flag set without overflow");

    property p_halt;
        st_reg.halt && !clr_wr |=> $stable(st_reg.count);
    endproperty
    a_halt: assert property (p_halt) else $error("count moved while halted");

    property p_clear;
        clr_wr |=> (st_reg.count == 16'h0000) && (st_reg.presc == 6'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("clear bit did not zero");

    property p_no_clock;
        (st_reg.div_sel == mtc_pkg::DIV_NONE) && !clr_wr |=> $stable(st_reg.count);
    endproperty
    a_no_clock: assert property (p_no_clock) else $error("counted with no source");

    property p_limit_inhibit;
        st_reg.limit_pend && !st_reg.ovf_flag |=> !st_reg.ovf_flag;
    endproperty
    a_limit_inhibit: assert property (p_limit_inhibit) else $error("flag in limit write");

    property p_break;
        break_active && !clr_wr |=> $stable(st_reg.count) and s_no_capture;
    endproperty
    a_break: assert property (p_break) else $error("activity during break");

    property p_lock;
        brk_lock && st_reg.ovf_flag |=> st_reg.ovf_flag;
    endproperty
    a_lock: assert property (p_lock) else $error("flag cleared in locked break");

    property p_ch_irq;
        channel_irq == (st_reg.ch_flag & st_reg.ch_ie);
    endproperty
    a_ch_irq: assert property (p_ch_irq) else $error("channel request wrong");

    property p_ovf_clear;
        wr_ctrl && st_reg.ovf_armed && !brk_lock && !hwdata[mtc_pkg::BIT_OVF_FLAG] && !ovf_set
            |=> !st_reg.ovf_flag;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("flag not cleared");

    property p_write_one;
        wr_ctrl && hwdata[mtc_pkg::BIT_OVF_FLAG] && st_reg.ovf_flag |=> st_reg.ovf_flag;
    endproperty
    a_write_one: assert property (p_write_one) else $error("write of one cleared flag");

    property p_count_up;
        tick && !clr_wr && (st_reg.count != st_reg.limit) |=> st_reg.count == $past(st_reg.count) + 16'h0001;
    endproperty
    a_count_up: assert property (p_count_up) else $error("count did not advance");

    property p_cap_halt;
        st_reg.halt |=> s_no_capture;
    endproperty
    a_cap_halt: assert property (p_cap_halt) else $error("capture while halted");

    property p_clear_reads;
        rd && (rd_addr == mtc_pkg::OFF_CTRL_STATUS) |=> !hrdata[mtc_pkg::BIT_CLEAR];
    endproperty
    a_clear_reads: assert property (p_clear_reads) else $error("clear bit read back one");

    property p_halt_clear;
        wr_ctrl && hwdata[mtc_pkg::BIT_HALT] && hwdata[mtc_pkg::BIT_CLEAR]
            |=> st_reg.halt && (st_reg.count == mtc_pkg::COUNT_ZERO);
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("not stopped at zero");

    property p_latch_take;
        rd && (rd_addr == mtc_pkg::OFF_COUNT_HIGH) && !st_reg.latch_held
            |=> st_reg.latch_held && (st_reg.low_latch == $past(st_reg.count[7:0]));
    endproperty
    a_latch_take: assert property (p_latch_take) else $error("low byte not latched");

    property p_latch_hold;
        st_reg.latch_held |=> $stable(st_reg.low_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched byte refreshed");

    property p_wait_refuse;
        hsel && htrans[1] && wait_mode |=> !st_reg.dp_wr && (hrdata == 32'h00000000);
    endproperty
    a_wait_refuse: assert property (p_wait_refuse) else $error("access in wait mode");

    property p_wake;
        wake_request == (overflow_irq || (|channel_irq));
    endproperty
    a_wake: assert property (p_wake) else $error("wake request wrong");

    property p_stop;
        stop_mode && !clr_wr |=> $stable(st_reg.count) && $stable(st_reg.presc);
    endproperty
    a_stop: assert property (p_stop) else $error("timer moved in stop mode");

    property p_release;
        wr_ctrl && break_active && break_clear_enable && st_reg.ovf_armed
            && !hwdata[mtc_pkg::BIT_OVF_FLAG] && !ovf_set |=> !st_reg.ovf_flag;
    endproperty
    a_release: assert property (p_release) else $error("flag kept in open break");

    property p_no_arm;
        brk_lock && !st_reg.ovf_armed |=> !st_reg.ovf_armed;
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("flag armed in locked break");
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the modulo timer core, driven over its register bus.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic   hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic        break_active = 1'b0;
    logic        break_clear_enable = 1'b0;
    logic [1:0]  capture_pin = 2'h0;
    logic [1:0]  compare_hit = 2'h0;
    logic        overflow_irq;
    logic [1:0]  channel_irq;
    logic        wake_request;
    int          bad_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic [15:0] v;
    logic [15:0] c1;
    logic [15:0] c2;

    // The single slave's ready output is the bus ready.
    assign hready = hreadyout;

    mtc_core u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .break_active(break_active),
        .break_clear_enable(break_clear_enable), .capture_pin(capture_pin),
        .compare_hit(compare_hit), .overflow_irq(overflow_irq), .channel_irq(channel_irq),
        .wake_request(wake_request)
    );

    initial begin
        forever #12.5 hclk = ~hclk;
    end

    task automatic report_and_stop;
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Single word transfer; entered just after a rising edge, returns on one.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdcnt(output logic [15:0] val);
        bus(1'b0, mtc_pkg::OFF_COUNT_HIGH, 32'h0);
        val[15:8] = rd[7:0];
        bus(1'b0, mtc_pkg::OFF_COUNT_LOW, 32'h0);
        val[7:0] = rd[7:0];
    endtask

    task automatic wait_high(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge hclk);
            n++;
        end
        check({31'h0, s}, 32'h1);
    endtask

    // Timeouts are counted as a mismatch so a hang still ends in the verdict.
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'h20);
        rdcnt(v);
        check({16'h0, v}, 32'h0);
        bus(1'b0, mtc_pkg::OFF_LIMIT_HIGH, 32'h0);
        check(rd, 32'hFF);
        bus(1'b0, mtc_pkg::OFF_LIMIT_LOW, 32'h0);
        check(rd, 32'hFF);
        bus(1'b1, mtc_pkg::OFF_COUNT_LOW, 32'hAA);
        bus(1'b0, mtc_pkg::OFF_COUNT_LOW, 32'h0);
        check(rd, 32'h0);
        // each divider code 0 to 6 gives eight ticks; code 7 gives none.
        for (int k = 0; k < 7; k++) begin
            bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h30 | 32'(k));
            bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'(k));
            repeat ((8 << k) + ((1 << k) >> 1) - 2) @(posedge hclk);
            bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h20 | 32'(k));
            rdcnt(v);
            check({31'h0, (k == 0) ? (v >= 7 && v <= 9) : (v == 16'h8)}, 32'h1);
        end
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h37);
        rdcnt(v);
        check({16'h0, v}, 32'h0);
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'h27);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h07);
        repeat (20) @(posedge hclk);
        rdcnt(v);
        check({16'h0, v}, 32'h0);
        // latched low byte, hold and resume.
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h00);
        repeat (3) @(posedge hclk);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h20);
        rdcnt(c1);
        bus(1'b0, mtc_pkg::OFF_COUNT_HIGH, 32'h0);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h00);
        repeat (5) @(posedge hclk);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h20);
        bus(1'b0, mtc_pkg::OFF_COUNT_HIGH, 32'h0);
        bus(1'b0, mtc_pkg::OFF_COUNT_LOW, 32'h0);
        check(rd, {24'h0, c1[7:0]});
        rdcnt(c2);
        rdcnt(v);
        check({16'h0, v}, {16'h0, c2});
        check({31'h0, c2 >= c1 + 16'h5 && c2 < c1 + 16'hC}, 32'h1);
        // stop and break freeze the count.
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h00);
        for (int s = 0; s < 2; s++) begin
            {break_active, stop_mode} <= 2'(s + 1);
            rdcnt(c1);
            repeat (10) @(posedge hclk);
            rdcnt(c2);
            check({16'h0, c2}, {16'h0, c1});
            {break_active, stop_mode} <= 2'h0;
            repeat (4) @(posedge hclk);
            rdcnt(c2);
            check({31'h0, c2 != c1}, 32'h1);
        end
        // overflow, clear sequence, protected in break.
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h30);
        bus(1'b1, mtc_pkg::OFF_LIMIT_HIGH, 32'h00);
        bus(1'b1, mtc_pkg::OFF_LIMIT_LOW, 32'h03);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h40);
        wait_high(overflow_irq, 40);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h60);
        check({31'h0, overflow_irq}, 32'h1);
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'hE0);
        break_active <= 1'b1;
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h60);
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'hE0);
        break_active <= 1'b0;
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h60);
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'h60);
        check({31'h0, overflow_irq}, 32'h0);
        // clearing allowed in break stays cleared.
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h40);
        wait_high(overflow_irq, 40);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h60);
        {break_active, break_clear_enable} <= 2'h3;
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h20);
        {break_active, break_clear_enable} <= 2'h0;
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'h20);
        // writing one and a later overflow both keep the flag.
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h40);
        wait_high(overflow_irq, 40);
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'hC0);
        repeat (20) @(posedge hclk);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h60);
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'hE0);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h60);
        // high limit write suppresses overflow until low written.
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h30);
        bus(1'b1, mtc_pkg::OFF_LIMIT_HIGH, 32'h00);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h40);
        repeat (20) @(posedge hclk);
        check({31'h0, overflow_irq}, 32'h0);
        bus(1'b1, mtc_pkg::OFF_LIMIT_LOW, 32'h03);
        wait_high(overflow_irq, 40);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h76);
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h66);
        // wait mode counts on, refuses access, wakes.
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h46);
        wait_mode <= 1'b1;
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'h0);
        check({31'h0, wake_request}, 32'h0);
        check({31'h0, hresp}, 32'h0);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h26);
        wait_high(wake_request, 400);
        wait_mode <= 1'b0;
        bus(1'b0, mtc_pkg::OFF_CTRL_STATUS, 32'h0);
        check(rd, 32'hC6);
        // capture suppressed while halted, then channel requests.
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h20);
        bus(1'b1, mtc_pkg::OFF_CHANNEL, 32'h230);
        capture_pin <= 2'h1;
        repeat (6) @(posedge hclk);
        check({30'h0, channel_irq}, 32'h0);
        bus(1'b1, mtc_pkg::OFF_CTRL_STATUS, 32'h00);
        capture_pin <= 2'h0;
        repeat (4) @(posedge hclk);
        capture_pin <= 2'h1;
        repeat (6) @(posedge hclk);
        check({30'h0, channel_irq}, 32'h1);
        compare_hit <= 2'h2;
        @(posedge hclk);
        compare_hit <= 2'h0;
        repeat (3) @(posedge hclk);
        check({30'h0, channel_irq}, 32'h3);
        report_and_stop();
    end
endmodule
`default_nettype wire
